// ---- rtl/accel_spi_pkg.sv ----
/*
  Shared constants for the accelerometer SPI slave: request and response
  field positions, codes, control register layout and timing counts.
  Assumes a 100 MHz core clock.
*/
package accel_spi_pkg;
  // ==========================================================
  // Frame and request layout
  localparam int FRAME_EDGES = 16;
  localparam int OP_HI = 15;
  localparam int OP_LO = 14;
  localparam int FETCH_BIT = 13;
  localparam int TAG_HIGH_BIT = 12;
  localparam logic [1:0] OP_ERROR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  // ==========================================================
  // Response layout
  localparam logic [1:0] KIND_SENSOR = 2'h1;
  localparam logic [1:0] KIND_SELF_TEST = 2'h2;
  localparam logic [1:0] KIND_NON_SENSOR = 2'h3;
  localparam logic [1:0] EXC_NON_SENSOR = 2'h2;
  localparam logic [1:0] EXC_SENSOR_FAULT = 2'h1;
  localparam int PARITY_BIT = 12;
  localparam int POWERED_DOWN_BIT = 3;
  localparam int LOOP_FAULT_BIT = 2;
  localparam logic [15:0] RESET_RESPONSE = 16'h0E03;
  // ==========================================================
  // Control register layout
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FREEZE_HI = 7;
  localparam int FREEZE_LO = 6;
  localparam int FILTER_CLEAR_BIT = 5;
  localparam int PATTERN_HI = 4;
  localparam int PATTERN_LO = 3;
  localparam int COMP_DISABLE_BIT = 2;
  localparam int SELF_CHECK_BIT = 1;
  localparam int SLEEP_BIT = 0;
  localparam logic [1:0] FREEZE_BOTH = 2'h0;
  localparam logic [1:0] FREEZE_CHANNEL = 2'h1;
  localparam logic [1:0] FREEZE_HIGH = 2'h2;
  localparam logic [1:0] FREEZE_NONE = 2'h3;
  // ==========================================================
  // Filter pattern values and settling
  localparam logic [1:0] PATTERN_OFF = 2'h0;
  localparam logic [1:0] PATTERN_25 = 2'h1;
  localparam logic [1:0] PATTERN_50 = 2'h2;
  localparam logic [13:0] PATTERN_25_VALUE = 14'h3400;
  localparam logic [13:0] PATTERN_50_VALUE = 14'h0000;
  localparam logic [13:0] PATTERN_75_VALUE = 14'h0C00;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_TIME_MS = 60;
  localparam int SETTLE_CYCLES = SETTLE_TIME_MS * CLK_MHZ * 1000;
endpackage : accel_spi_pkg

// ---- rtl/spi_link_if.sv ----
/*
  Carrier between the SPI frame shifter and the protocol core.
  Assumes both ends run on the same core clock.
*/
interface spi_link_if;
  logic frame_done;
  logic [15:0] rx_word;
  logic [4:0] edge_count;
  logic [15:0] tx_word;
  modport shifter (output frame_done, output rx_word, output edge_count, input tx_word);
  modport core (input frame_done, input rx_word, input edge_count, output tx_word);
endinterface : spi_link_if

// ---- rtl/spi_frame_shifter.sv ----
/*
  Samples the SPI pins on the core clock, shifts requests in and the
  pending response out, and counts rising clock edges per frame.
  Assumes the link clock is at most one eighth of the core clock.
*/
module spi_frame_shifter
  import accel_spi_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // SPI pins.
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Link to the protocol core.
  spi_link_if.shifter link
);
  typedef struct packed {
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic sel_meta;
    logic sel_sync;
    logic sel_prev;
    logic mosi_meta;
    logic mosi_sync;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [4:0] cnt;
    logic miso;
    logic oe;
    logic done;
    logic [15:0] rx_word;
    logic [4:0] edge_count;
  } shift_s;

  shift_s s;
  shift_s next_s;
  logic sel_fall;
  logic sel_rise;
  logic clk_rise;
  logic clk_fall;

  // ==========================================================
  // Edge detection works on the second sync stage only, so the
  // metastable first stage never reaches any decision.
  always_comb begin
    sel_fall = s.sel_prev & ~s.sel_sync;
    sel_rise = ~s.sel_prev & s.sel_sync;
    clk_rise = ~s.sclk_prev & s.sclk_sync & ~s.sel_sync;
    clk_fall = s.sclk_prev & ~s.sclk_sync & ~s.sel_sync;
    next_s = s;
    next_s.sclk_meta = sclk;
    next_s.sclk_sync = s.sclk_meta;
    next_s.sclk_prev = s.sclk_sync;
    next_s.sel_meta = frame_select_n;
    next_s.sel_sync = s.sel_meta;
    next_s.sel_prev = s.sel_sync;
    next_s.mosi_meta = mosi;
    next_s.mosi_sync = s.mosi_meta;
    next_s.done = 1'b0;
    if (sel_fall) begin
      next_s.tx = link.tx_word;
      next_s.miso = link.tx_word[15];
      next_s.oe = 1'b1;
      next_s.cnt = 5'h00;
    end
    if (clk_rise) begin
      next_s.rx = {s.rx[14:0], s.mosi_sync};
      if (s.cnt != 5'h1F) begin
        next_s.cnt = s.cnt + 5'h01;
      end
    end
    // A falling edge before any rising edge carries no new bit.
    if (clk_fall && s.cnt != 5'h00) begin
      next_s.tx = {s.tx[14:0], 1'b0};
      next_s.miso = s.tx[14];
    end
    if (sel_rise) begin
      next_s.done = 1'b1;
      next_s.rx_word = s.rx;
      next_s.edge_count = s.cnt;
      next_s.oe = 1'b0;
      next_s.miso = 1'b0;
    end
  end

  // ==========================================================
  // Select idles high, clock idles low after reset.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.sel_meta <= 1'b1;
      s.sel_sync <= 1'b1;
      s.sel_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign miso = s.miso;
  assign miso_oe = s.oe;
  assign link.frame_done = s.done;
  assign link.rx_word = s.rx_word;
  assign link.edge_count = s.edge_count;
endmodule : spi_frame_shifter

// ---- rtl/axis_filter_stage.sv ----
/*
  Digital filter stage for both axes: filter reset, pattern test inputs
  and settling delay. Assumes raw samples arrive on the core clock.
*/
module axis_filter_stage
  import accel_spi_pkg::*;
#(
  parameter int unsigned SETTLE = SETTLE_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Controls and raw samples.
  input wire logic filter_clear,
  input wire logic [1:0] pattern_mode,
  input wire logic [13:0] raw_x,
  input wire logic [13:0] raw_y,
  // Filtered samples.
  output logic [13:0] out_x,
  output logic [13:0] out_y
);
  typedef struct packed {
    logic [31:0] wait_cnt;
    logic [1:0] mode_prev;
    logic [13:0] x;
    logic [13:0] y;
  } filt_s;

  filt_s s;
  filt_s next_s;
  logic [13:0] target;

  // ==========================================================
  // Pattern outputs appear only after the settling time, which
  // restarts whenever the mode changes or the filter is cleared.
  always_comb begin
    next_s = s;
    next_s.mode_prev = pattern_mode;
    unique case (pattern_mode)
      PATTERN_OFF: target = 14'h0000;
      PATTERN_25: target = PATTERN_25_VALUE;
      PATTERN_50: target = PATTERN_50_VALUE;
      default: target = PATTERN_75_VALUE;
    endcase
    if (filter_clear) begin
      next_s.x = 14'h0000;
      next_s.y = 14'h0000;
      next_s.wait_cnt = SETTLE;
    end else if (pattern_mode != s.mode_prev) begin
      next_s.wait_cnt = SETTLE;
    end else if (pattern_mode == PATTERN_OFF) begin
      next_s.x = raw_x;
      next_s.y = raw_y;
    end else if (s.wait_cnt != 32'h00000000) begin
      next_s.wait_cnt = s.wait_cnt - 32'h00000001;
    end else begin
      next_s.x = target;
      next_s.y = target;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_x = s.x;
  assign out_y = s.y;
endmodule : axis_filter_stage

// ---- rtl/accel_spi_slave_ctrl.sv ----
/*
  Protocol core of the accelerometer SPI slave: decodes requests, keeps
  the control register and output hold registers, builds responses.
  Assumes an external SPI master and raw samples on the core clock.
*/
// Notes on behaviour
// - Granted register requests echo opcode in 14:13.
// - Bit 12 makes the word odd parity.
// - Non-sensor responses carry content kind 11.
// - Non-sensor responses except fetch faults carry exception kind 10.
// - Sixteen clock edges per frame, else fault.
// - Unknown request sets the bad request flag.
// - Error data: zeros, then three flags.
// - Write answer returns the written value.
// - Register requests ignore address, one register.
// - Opcode 01 writes, 10 reads control.
// - Fetch requests carry three sample tag bits.
// - Bits 1:0 pick axis and byte.
// - Fetch reports power down and loop faults.
// - First answer after reset: bad request, unavailable.
// - Bits 7:6 select output freeze mode.
// - Filter clear holds filters at zero.
// - Bits 4:3 choose filter test pattern.
// - Bit 2 turns compensation off.
// - Bit 1 enables self-test.
// - Bit 0 enters power down.
// - Control register resets to zero.
// - Self-test fetch answers content kind 10.
// - Freeze modes hold outputs until reads complete.
// - Sample splits into ten high, four low.
module accel_spi_slave_ctrl
  import accel_spi_pkg::*;
#(
  parameter int unsigned SETTLE = SETTLE_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // SPI pins.
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Sensing path.
  input wire logic [13:0] raw_x,
  input wire logic [13:0] raw_y,
  input wire logic loop_fault_pin,
  // Control outputs to the analogue side.
  output logic comp_disable,
  output logic self_check_enable,
  output logic sleep_enable
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] tx_word;
    logic [13:0] hold_x;
    logic [13:0] hold_y;
    logic [3:0] read_seen;
    logic frz_x;
    logic frz_y;
    logic fault_meta;
    logic fault_sync;
  } core_s;

  core_s s;
  core_s next_s;
  spi_link_if link ();
  logic [13:0] filt_x;
  logic [13:0] filt_y;
  logic [15:0] req;
  logic [1:0] mode;
  logic chan_y;
  logic high_byte;
  logic [13:0] sample;
  logic [9:0] payload;
  logic [1:0] kind;

  // ==========================================================
  // Response builders
  // The parity bit is chosen last so the whole word has odd parity.
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[PARITY_BIT] = 1'b0;
    r[PARITY_BIT] = ~(^r);
    return r;
  endfunction : with_parity

  function automatic logic [15:0] status_word(input logic [1:0] op, input logic [7:0] data);
    logic [15:0] r;
    r = {1'b0, op, 1'b0, KIND_NON_SENSOR, EXC_NON_SENSOR, data};
    return with_parity(r);
  endfunction : status_word

  function automatic logic [15:0] error_word(input logic count_fault, input logic bad_req);
    return status_word(OP_ERROR, {5'h00, count_fault, bad_req, 1'b0});
  endfunction : error_word

  // ==========================================================
  // Frame shifter and filter stage
  spi_frame_shifter u_shifter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .frame_select_n(frame_select_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .link(link.shifter)
  );

  axis_filter_stage #(
    .SETTLE(SETTLE)
  ) u_filter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .filter_clear(s.ctrl[FILTER_CLEAR_BIT]),
    .pattern_mode(s.ctrl[PATTERN_HI:PATTERN_LO]),
    .raw_x(raw_x),
    .raw_y(raw_y),
    .out_x(filt_x),
    .out_y(filt_y)
  );

  // ==========================================================
  // Request decode, freeze bookkeeping and response selection.
  // The response is prepared at the end of a frame and shifted out
  // during the next one, so a slow master never races the decode.
  always_comb begin
    next_s = s;
    next_s.fault_meta = loop_fault_pin;
    next_s.fault_sync = s.fault_meta;
    req = link.rx_word;
    mode = s.ctrl[FREEZE_HI:FREEZE_LO];
    chan_y = req[1];
    high_byte = ~req[0];
    sample = chan_y ? s.hold_y : s.hold_x;
    payload = high_byte ? sample[13:4] : {6'h00, sample[3:0]};
    kind = s.ctrl[SELF_CHECK_BIT] ? KIND_SELF_TEST : KIND_SENSOR;
    if (link.frame_done) begin
      if (link.edge_count != 5'(FRAME_EDGES)) begin
        // A mangled frame is not acted on; only the fault is reported.
        next_s.tx_word = error_word(1'b1, 1'b0);
      end else if (req[FETCH_BIT]) begin
        if (req[3:2] != 2'h0) begin
          next_s.tx_word = error_word(1'b0, 1'b1);
        end else if (s.ctrl[SLEEP_BIT] || s.fault_sync) begin
          next_s.tx_word = with_parity({req[TAG_HIGH_BIT], req[OP_HI], req[OP_LO], 1'b0,
              KIND_NON_SENSOR, EXC_SENSOR_FAULT, 4'h0, s.ctrl[SLEEP_BIT], s.fault_sync,
              2'h0});
        end else begin
          next_s.tx_word = with_parity({req[TAG_HIGH_BIT], req[OP_HI], req[OP_LO], 1'b0,
              kind, payload});
          // Freeze handling per output mode.
          unique case (mode)
            FREEZE_BOTH: begin
              next_s.read_seen[{chan_y, ~high_byte}] = 1'b1;
              if (&next_s.read_seen) begin
                next_s.read_seen = 4'h0;
                next_s.frz_x = 1'b0;
                next_s.frz_y = 1'b0;
              end else begin
                next_s.frz_x = 1'b1;
                next_s.frz_y = 1'b1;
              end
            end
            FREEZE_CHANNEL: begin
              next_s.read_seen[{chan_y, ~high_byte}] = 1'b1;
              if (&next_s.read_seen[{chan_y, 1'b0} +: 2]) begin
                next_s.read_seen[{chan_y, 1'b0} +: 2] = 2'h0;
                if (chan_y) next_s.frz_y = 1'b0;
                else next_s.frz_x = 1'b0;
              end else begin
                if (chan_y) next_s.frz_y = 1'b1;
                else next_s.frz_x = 1'b1;
              end
            end
            FREEZE_HIGH: begin
              if (high_byte) begin
                next_s.read_seen[{chan_y, 1'b0}] = 1'b1;
                if (next_s.read_seen[0] && next_s.read_seen[2]) begin
                  next_s.read_seen = 4'h0;
                  next_s.frz_x = 1'b0;
                  next_s.frz_y = 1'b0;
                end else begin
                  next_s.frz_x = 1'b1;
                  next_s.frz_y = 1'b1;
                end
              end
            end
            default: begin
              next_s.read_seen = 4'h0;
            end
          endcase
        end
      end else begin
        // Address bits are never decoded: there is one register.
        unique case (req[OP_HI:OP_LO])
          OP_WRITE: begin
            next_s.ctrl = req[7:0];
            next_s.tx_word = status_word(OP_WRITE, req[7:0]);
          end
          OP_READ: begin
            next_s.tx_word = status_word(OP_READ, s.ctrl);
          end
          default: begin
            next_s.tx_word = error_word(1'b0, 1'b1);
          end
        endcase
      end
    end
    // Continuous mode never leaves stale freezes behind.
    if (next_s.ctrl[FREEZE_HI:FREEZE_LO] == FREEZE_NONE) begin
      next_s.frz_x = 1'b0;
      next_s.frz_y = 1'b0;
      next_s.read_seen = 4'h0;
    end
    // A channel freezing now keeps the value just reported.
    next_s.hold_x = next_s.frz_x ? s.hold_x : filt_x;
    next_s.hold_y = next_s.frz_y ? s.hold_y : filt_y;
  end

  // ==========================================================
  // State registers.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.tx_word <= RESET_RESPONSE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Control outputs come straight from the register bits.
  assign comp_disable = s.ctrl[COMP_DISABLE_BIT];
  assign self_check_enable = s.ctrl[SELF_CHECK_BIT];
  assign sleep_enable = s.ctrl[SLEEP_BIT];
  assign link.tx_word = s.tx_word;
endmodule : accel_spi_slave_ctrl

// ---- verification/spi_master_model.sv ----
/*
  Behavioural SPI master for the accelerometer slave bench.
  Assumes a 100 MHz core clock; pins change on its falling edge.
*/
module spi_master_model (
  // Clock.
  input wire logic core_clk,
  // SPI pins.
  output logic sclk,
  output logic frame_select_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Idle pins: clock stands low, select is high.
  initial begin
    sclk = 1'b0;
    frame_select_n = 1'b1;
    mosi = 1'b0;
  end
  // Half of the 80 ns link period.
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask : half
  // One frame; edges other than 16 break the framing on purpose.
  task automatic xfer(input logic [15:0] req, input int edges, output logic [15:0] rsp);
    rsp = 16'h0000;
    @(negedge core_clk);
    frame_select_n = 1'b0;
    half();
    half();
    for (int i = 0; i < edges; i++) begin
      mosi = (i < 16) ? req[15 - i] : 1'b0;
      half();
      rsp = {rsp[14:0], miso};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    frame_select_n = 1'b1;
    // A released line must not keep its last value.
    mosi = ~mosi;
    repeat (6) @(negedge core_clk);
  endtask : xfer
endmodule : spi_master_model

// ---- verification/accel_spi_slave_ctrl_properties.sv ----
/*
  Checker for the SPI slave top: framing, answer words, control outputs.
  Assumes pins driven between rising core clock edges.
*/
module accel_spi_slave_ctrl_properties (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Pins.
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic comp_disable,
  input wire logic self_check_enable,
  input wire logic sleep_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] word;
  logic [4:0] bits;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Rebuild each answer from miso at sclk rises; count saturates.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word <= 16'h0000;
      bits <= 5'h00;
    end else if ($fell(frame_select_n)) begin
      bits <= 5'h00;
    end else if (!frame_select_n && $rose(sclk)) begin
      word <= {word[14:0], miso};
      bits <= (bits == 5'h1F) ? bits : bits + 5'h01;
    end
  end
  sequence s_end;
    $rose(frame_select_n) && bits == 5'h10;
  endsequence
  // ==========================================================
  // Properties.
  a_oe_idle_low: assert property (frame_select_n [*6] |-> !miso_oe)
    else $error("miso enabled outside a frame");
  a_miso_idle_zero: assert property (!miso_oe |-> !miso)
    else $error("miso high while not enabled");
  a_oe_rise_bound: assert property ($fell(frame_select_n) |-> ##[1:5] miso_oe)
    else $error("miso not enabled after select");
  a_miso_hold_high: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
  a_ctrl_frame_stable: assert property (!frame_select_n [*4] |->
    $stable({comp_disable, self_check_enable, sleep_enable}))
    else $error("control outputs moved inside a frame");
  a_ctrl_reset_zero: assert property ($rose(reset_n) |->
    {comp_disable, self_check_enable, sleep_enable} == 3'h0)
    else $error("control outputs not clear after reset");
  a_parity_odd: assert property (s_end |-> (^word) == 1'b1)
    else $error("answer word parity not odd");
  a_nonsensor_top: assert property (s_end |-> word[11:8] != 4'hE || !word[15])
    else $error("bit 15 set in register answer");
  a_error_data_zero: assert property (s_end |->
    word[14:13] != 2'h0 || word[11:8] != 4'hE || word[7:3] == 5'h00)
    else $error("error answer data bits not zero");
  c_full_frame: cover property (s_end);
  c_sleep_on: cover property ($rose(sleep_enable));
  c_self_check: cover property ($rose(self_check_enable));
endmodule : accel_spi_slave_ctrl_properties

bind accel_spi_slave_ctrl accel_spi_slave_ctrl_properties u_props (
  .core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .frame_select_n(frame_select_n),
  .miso(miso), .miso_oe(miso_oe), .comp_disable(comp_disable),
  .self_check_enable(self_check_enable), .sleep_enable(sleep_enable));

// ---- verification/accel_spi_slave_ctrl_tb_top.sv ----
/*
  Self-checking bench for the accelerometer SPI slave.
  Assumes the master model and checker are compiled first.
*/
module accel_spi_slave_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic loop_fault_pin = 1'b0;
  logic [13:0] raw_x = 14'h2ABC;
  logic [13:0] raw_y = 14'h1234;
  logic sclk, frame_select_n, mosi, miso, miso_oe;
  logic comp_disable, self_check_enable, sleep_enable;
  logic [15:0] rsp;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  // ==========================================================
  // 100 MHz clock.
  always #5 core_clk = ~core_clk;
  accel_spi_slave_ctrl #(.SETTLE(20)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .sclk(sclk), .frame_select_n(frame_select_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .raw_x(raw_x), .raw_y(raw_y), .loop_fault_pin(loop_fault_pin),
    .comp_disable(comp_disable), .self_check_enable(self_check_enable),
    .sleep_enable(sleep_enable));
  spi_master_model master (.core_clk(core_clk), .sclk(sclk),
    .frame_select_n(frame_select_n), .mosi(mosi), .miso(miso));
  // ==========================================================
  // Helpers.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_w
  task automatic chk_b(input string what, input logic exp, input logic got);
    chk_w(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_b
  // Fills bit 12 so that the whole word has odd parity.
  function automatic logic [15:0] odd(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[12] = 1'b0;
    r[12] = ~^r;
    return r;
  endfunction : odd
  function automatic logic [15:0] reg_rsp(input logic [1:0] op, input logic [7:0] d);
    return odd({1'b0, op, 1'b0, 4'hE, d});
  endfunction : reg_rsp
  function automatic logic [15:0] sens(input logic [1:0] kind, input logic [9:0] d);
    return odd({4'h0, kind, d});
  endfunction : sens
  // Every answer except the reset answer belongs to the frame before this one.
  task automatic xf(input logic [15:0] req);
    master.xfer(req, 16, rsp);
  endtask : xf
  task automatic do_reset();
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask : do_reset
  // ==========================================================
  // Scenarios.
  // The reset answer is shifted out during the first frame itself.
  task automatic t_first_answer();
    xf(16'h8000);
    chk_w("first answer", reg_rsp(2'h0, 8'h03), rsp);
    xf(16'h8000);
    chk_w("reset ctrl", reg_rsp(2'h2, 8'h00), rsp);
  endtask : t_first_answer
  // Address bits are set to show that they are ignored.
  task automatic t_write_read();
    xf(16'h5F07);
    xf(16'h9A00);
    chk_w("write status", reg_rsp(2'h1, 8'h07), rsp);
    chk_b("comp", 1'b1, comp_disable);
    chk_b("self", 1'b1, self_check_enable);
    chk_b("sleep", 1'b1, sleep_enable);
    xf(16'h8000);
    chk_w("read back", reg_rsp(2'h2, 8'h07), rsp);
  endtask : t_write_read
  task automatic t_bad_request();
    logic [15:0] bad[4] = '{16'h0000, 16'hC0FF, 16'h2004, 16'h200C};
    foreach (bad[i]) begin
      xf(bad[i]);
      xf(16'h8000);
      chk_w("bad request", reg_rsp(2'h0, 8'h02), rsp);
    end
  endtask : t_bad_request
  task automatic t_wrong_count();
    int n[2] = '{15, 17};
    foreach (n[i]) begin
      master.xfer(16'h40FF, n[i], rsp);
      xf(16'h8000);
      chk_w("count fault", reg_rsp(2'h0, 8'h04), rsp);
      xf(16'h8000);
      chk_w("not written", reg_rsp(2'h2, 8'h07), rsp);
    end
  endtask : t_wrong_count
  // Sleep is on here; tag bits differ between the two requests.
  task automatic t_fetch_fault();
    xf(16'hB000);
    loop_fault_pin = 1'b1;
    xf(16'h7000);
    chk_w("sleep fault", odd({4'hC, 4'hD, 8'h08}), rsp);
    xf(16'h8000);
    chk_w("loop fault", odd({4'hA, 4'hD, 8'h0C}), rsp);
    loop_fault_pin = 1'b0;
  endtask : t_fetch_fault
  task automatic t_sensor_data();
    logic [9:0] d[4];
    d = '{raw_x[13:4], {6'h00, raw_x[3:0]}, raw_y[13:4], {6'h00, raw_y[3:0]}};
    xf(16'h40C0);
    xf(16'h2000);
    for (int i = 1; i <= 4; i++) begin
      xf(i < 4 ? (16'h2000 | 16'(i)) : 16'h8000);
      chk_w("axis data", sens(2'h1, d[i - 1]), rsp);
    end
    xf(16'h40C2);
    xf(16'h2000);
    xf(16'h8000);
    chk_w("self test", sens(2'h2, d[0]), rsp);
  endtask : t_sensor_data
  // A high read in mode 10 must hold the other axis.
  task automatic t_freeze();
    logic [13:0] y0;
    y0 = raw_y;
    xf(16'h4080);
    xf(16'h2000);
    raw_y = 14'h0555;
    repeat (4) @(negedge core_clk);
    xf(16'h2002);
    xf(16'h40C0);
    chk_w("frozen y", sens(2'h1, y0[13:4]), rsp);
    xf(16'h2002);
    xf(16'h8000);
    chk_w("free y", sens(2'h1, raw_y[13:4]), rsp);
  endtask : t_freeze
  // Modes 01 then 00: a read holds the sample until its partners are read.
  task automatic t_freeze_modes();
    logic [13:0] y0;
    xf(16'h4040);
    y0 = raw_y;
    xf(16'h2002);
    raw_y = 14'h1ABC;
    repeat (4) @(negedge core_clk);
    xf(16'h2003);
    xf(16'h2002);
    chk_w("channel held", sens(2'h1, {6'h00, y0[3:0]}), rsp);
    xf(16'h2003);
    chk_w("channel freed", sens(2'h1, raw_y[13:4]), rsp);
    xf(16'h4000);
    y0 = raw_y;
    xf(16'h2000);
    raw_y = 14'h0F0F;
    repeat (4) @(negedge core_clk);
    xf(16'h2002);
    xf(16'h2001);
    chk_w("both held", sens(2'h1, y0[13:4]), rsp);
    xf(16'h2003);
    xf(16'h2002);
    xf(16'h40C0);
    chk_w("both freed", sens(2'h1, raw_y[13:4]), rsp);
  endtask : t_freeze_modes
  // Clear, then the three patterns; -3072 and +3072 as 14-bit words.
  task automatic t_filter();
    logic [7:0] m[4] = '{8'hE0, 8'hC8, 8'hD0, 8'hD8};
    logic [13:0] pv[4] = '{14'h0000, 14'h3400, 14'h0000, 14'h0C00};
    foreach (m[i]) begin
      xf({8'h40, m[i]});
      repeat (40) @(negedge core_clk);
      xf(16'h2000);
      xf(16'h8000);
      chk_w("filter x", sens(2'h1, pv[i][13:4]), rsp);
    end
  endtask : t_filter
  // ==========================================================
  // Main sequence, with a second reset in mid-run.
  initial begin
    do_reset();
    t_first_answer();
    t_write_read();
    t_bad_request();
    t_wrong_count();
    t_fetch_fault();
    t_sensor_data();
    t_freeze();
    t_freeze_modes();
    t_filter();
    do_reset();
    t_first_answer();
    end_of_test();
  end
  // Cuts a hang short well above the expected run of some 9000 cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
endmodule : accel_spi_slave_ctrl_tb_top
